// file: core/cbfc_consts.svh
// constants for the configuration bit stream frame checker
// Overview of operation
// RULE_01: byte-wide source sends preamble F2 as one byte, 8n+4 leading ones, 8n trailing.
// RULE_02: after the preamble a 24-bit length count of configuration clocks is taken.
// RULE_03: identification frame: header 0101 then twelve ones, mode, 42 zero bits, id, checksum.
// RULE_04: mode field 00 selects automatic address stepping, 01 explicit addressing.
// RULE_05: received 20-bit part id differing from own part code raises identity error.
// RULE_06: data frame: header 01, payload, zero padding to a byte, checksum byte.
// RULE_07: payload bits per frame and frame count are device-size parameters.
// RULE_08: address frame: header 00, 14-bit store address, checksum byte.
// RULE_09: every frame is followed by eight high stop bits.
// RULE_10: postamble: header 00, 14 ones, 16 stop bits, or 32 on processor port.
// RULE_11: postamble is an address frame with highest address and all-ones checksum.
// RULE_12: in explicit mode the source sends address frames after each data frame.
// RULE_13: byte-wide source sends stop bits per frame in multiples of eight.
// RULE_14: a zero among the stop bits before a frame start raises alignment error.
// RULE_15: checksum is the XOR of all frame bytes before the checksum byte.
// RULE_16: received checksum differing from computed value raises checksum error.
// RULE_17: any error halts in idle with error pin low until reset or program.
// RULE_18: the kind of error is recorded in a register readable by the processor.
// RULE_19: writing the program bit clears the error and restarts configuration.
// RULE_20: automatic stepping stores each data frame at next address from zero.
`ifndef CBFC_CONSTS_SVH
`define CBFC_CONSTS_SVH
`define PREAMBLE 8'hF2
`define LEN_LAST 6'h17
`define CSUM_LAST 6'h07
`define STOP_BITS 4'h8
`define POST_STOP 6'h10
`define POST_STOP_MPI 6'h20
`define ID_HDR_END 9'h00F
`define ID_MODE_HI 9'h010
`define ID_MODE_LO 9'h011
`define ID_RSV_END 9'h03B
`define ID_LAST 9'h04F
`define ADDR_LAST 9'h00F
`define POS_START 9'h001
`define POS_HDR2 9'h002
`define POS_HDR3 9'h003
`define ADDR_ONES 14'h3FFF
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_LEN 4'h2
`define REG_FRAMES 4'h3
`define CTRL_PROG 0
`define CTRL_MPI 1
`endif

// file: core/cbfc_pkg.sv
// types shared by the frame checker
package cbfc_pkg;
  typedef enum logic [2:0] {
    CBFC_HUNT = 3'b000,
    CBFC_LEN = 3'b001,
    CBFC_GAP = 3'b010,
    CBFC_FRAME = 3'b011,
    CBFC_CSUM = 3'b100,
    CBFC_POST = 3'b101,
    CBFC_DONE = 3'b110,
    CBFC_ERR = 3'b111
  } cbfc_state_e;
  typedef enum logic [1:0] {
    CBFC_F_ID = 2'b00,
    CBFC_F_DATA = 2'b01,
    CBFC_F_ADDR = 2'b10
  } cbfc_frame_e;
endpackage

// file: core/cbfc_pin_sync.sv
// three-stage synchroniser for pins; a change counts once stages two and three agree
`timescale 1ns/1ns
module cbfc_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] init,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;
  logic [WIDTH-1:0] rst_seen;

  assign rst_seen = '0;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff[g] <= 1'b1;
          s2_ff[g] <= 1'b1;
          s3_ff[g] <= 1'b1;
          lvl_ff[g] <= 1'b1;
        end else begin
          s1_ff[g] <= pin[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin
            lvl_ff[g] <= s3_ff[g] ^ rst_seen[g] ^ init[g];
          end
        end
      end
    end
  endgenerate

  assign level = lvl_ff;
endmodule

// file: core/cbfc_checker.sv
// serial configuration bit stream parser and frame checker
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "cbfc_consts.svh"
module cbfc_checker import cbfc_pkg::*; #(
  parameter int DATA_BITS = 202,
  parameter int FRAMES = 856,
  parameter logic [19:0] PART_CODE = 20'h5A3C1 // value arbitrary
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_clk_pin,
  input wire logic cfg_data_pin,
  input wire logic program_request_pin_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  output logic init_n_ff,
  output logic done_ff,
  output logic store_ff,
  output logic [13:0] store_addr_ff,
  output logic payload_bit_ff,
  output logic payload_vld_ff
);
  // ----------------------------------------------------------------
  // derived sizes
  // ----------------------------------------------------------------
  // RULE_06 header plus payload rounded up to whole bytes
  localparam int DBODY = ((2 + DATA_BITS + 7) / 8) * 8;
  localparam logic [8:0] DATA_LAST = 9'(DBODY - 1);
  localparam logic [8:0] PAY_LAST = 9'(DATA_BITS + 1);
  localparam logic [13:0] FRAME_CNT = 14'(FRAMES);

  // ----------------------------------------------------------------
  // pin synchronisation and bit events
  // ----------------------------------------------------------------
  logic [2:0] pin_q;
  logic cclk_prev_ff;
  logic bit_ev;
  logic bit_in;
  logic prog_pin_n;

  cbfc_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({program_request_pin_n, cfg_data_pin, cfg_clk_pin}),
    .init(3'h0),
    .level(pin_q)
  );

  assign bit_in = pin_q[1];
  assign prog_pin_n = pin_q[2];
  // data and clock pass the same stages, so data is stable at the edge
  assign bit_ev = pin_q[0] & ~cclk_prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cclk_prev_ff <= 1'b1;
    end else begin
      cclk_prev_ff <= pin_q[0];
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic mpi_mode_ff;
  logic prog_wr;
  logic restart;

  assign prog_wr = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_PROG];
  // RULE_19 program bit or program pin restarts
  assign restart = prog_wr || !prog_pin_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mpi_mode_ff <= 1'b0;
    end else if (reg_wr && (reg_addr == `REG_CTRL)) begin
      mpi_mode_ff <= reg_wdata[`CTRL_MPI];
    end
  end

  // ----------------------------------------------------------------
  // parser state
  // ----------------------------------------------------------------
  cbfc_state_e st_ff;
  cbfc_frame_e ftype_ff;
  logic [8:0] pos_ff;
  logic [5:0] cnt_ff;
  logic [3:0] ones_ff;
  logic [7:0] shift_ff;
  logic [7:0] csum_ff;
  logic [23:0] field_ff;
  logic [23:0] len_ff;
  logic explicit_ff;
  logic id_seen_ff;
  logic [7:0] nxt_shift;
  logic [23:0] nxt_field;
  logic [8:0] body_last;
  logic [5:0] post_last;
  logic in_frame;
  logic in_id;
  logic id_bad;
  logic align_bad;
  logic csum_last;
  logic csum_bad;
  logic any_bad;
  logic frame_ok;
  logic post_hit;

  assign nxt_shift = {shift_ff[6:0], bit_in};
  assign nxt_field = {field_ff[22:0], bit_in};
  assign in_frame = bit_ev && (st_ff == CBFC_FRAME);
  assign in_id = in_frame && (ftype_ff == CBFC_F_ID) && (pos_ff >= `POS_HDR2);
  assign body_last = (ftype_ff == CBFC_F_ID) ? `ID_LAST :
                     (ftype_ff == CBFC_F_DATA) ? DATA_LAST : `ADDR_LAST;
  // RULE_10 processor-port loading ends with twice the stop bits
  assign post_last = (mpi_mode_ff ? `POST_STOP_MPI : `POST_STOP) - 6'h01;

  // RULE_03 identification header, mode and reserved field checks
  // RULE_05 part code compare at the last id bit
  assign id_bad = (in_frame && (pos_ff == `POS_START) && !id_seen_ff && !bit_in) ||
                  (in_id && (pos_ff == `POS_HDR2) && bit_in) ||
                  (in_id && (pos_ff >= `POS_HDR3) && (pos_ff <= `ID_HDR_END) && !bit_in) ||
                  (in_id && (pos_ff == `ID_MODE_HI) && bit_in) ||
                  (in_id && (pos_ff > `ID_MODE_LO) && (pos_ff <= `ID_RSV_END) && bit_in) ||
                  (in_id && (pos_ff == `ID_LAST) && (nxt_field[19:0] != PART_CODE));

  // RULE_14 too few stop bits before a start pair
  assign align_bad = bit_ev && !bit_in &&
                     (((st_ff == CBFC_GAP) && (ones_ff < `STOP_BITS)) ||
                      (st_ff == CBFC_POST));

  // RULE_16 received byte against running XOR
  assign csum_last = bit_ev && (st_ff == CBFC_CSUM) && (cnt_ff == `CSUM_LAST);
  assign csum_bad = csum_last && (nxt_shift != csum_ff);
  assign frame_ok = csum_last && !csum_bad;
  assign any_bad = id_bad || align_bad || csum_bad;

  // RULE_11 all-ones address marks the postamble
  assign post_hit = in_frame && (ftype_ff == CBFC_F_ADDR) && (pos_ff == `ADDR_LAST) &&
                    (nxt_field[13:0] == `ADDR_ONES);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= CBFC_HUNT;
      ftype_ff <= CBFC_F_ID;
      pos_ff <= 9'h000;
      cnt_ff <= 6'h00;
      ones_ff <= 4'h0;
      shift_ff <= 8'h00;
      csum_ff <= 8'h00;
      field_ff <= 24'h000000;
      len_ff <= 24'h000000;
      explicit_ff <= 1'b0;
      id_seen_ff <= 1'b0;
    end else if (restart) begin
      st_ff <= CBFC_HUNT;
      shift_ff <= 8'h00;
      id_seen_ff <= 1'b0;
      explicit_ff <= 1'b0;
    end else if (bit_ev) begin
      case (st_ff)
        CBFC_HUNT: begin
          shift_ff <= nxt_shift;
          if (nxt_shift == `PREAMBLE) begin
            st_ff <= CBFC_LEN;
            cnt_ff <= 6'h00;
          end
        end
        CBFC_LEN: begin
          // RULE_02 length count, most significant bit first
          field_ff <= nxt_field;
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == `LEN_LAST) begin
            len_ff <= nxt_field;
            st_ff <= CBFC_GAP;
            ones_ff <= 4'h0;
          end
        end
        CBFC_GAP: begin
          // RULE_09 stop bits separate frames
          if (bit_in) begin
            if (ones_ff < `STOP_BITS) begin
              ones_ff <= ones_ff + 4'h1;
            end
          end else if (align_bad) begin
            st_ff <= CBFC_ERR;
          end else begin
            st_ff <= CBFC_FRAME;
            pos_ff <= `POS_START;
            shift_ff <= nxt_shift;
            csum_ff <= 8'h00;
          end
        end
        CBFC_FRAME: begin
          shift_ff <= nxt_shift;
          field_ff <= nxt_field;
          pos_ff <= pos_ff + 9'h001;
          // RULE_15 fold each completed byte
          if (pos_ff[2:0] == 3'h7) begin
            csum_ff <= csum_ff ^ nxt_shift;
          end
          if (pos_ff == `POS_START) begin
            // RULE_06 header 01 is data, RULE_08 header 00 is address
            if (!id_seen_ff) begin
              ftype_ff <= CBFC_F_ID;
            end else if (bit_in) begin
              ftype_ff <= CBFC_F_DATA;
            end else begin
              ftype_ff <= CBFC_F_ADDR;
            end
          end
          // RULE_04 low mode bit picks explicit addressing
          if ((ftype_ff == CBFC_F_ID) && (pos_ff == `ID_MODE_LO)) begin
            explicit_ff <= bit_in;
          end
          if (id_bad) begin
            st_ff <= CBFC_ERR;
          end else if (post_hit) begin
            st_ff <= CBFC_POST;
            cnt_ff <= 6'h00;
          end else if (pos_pos_last(pos_ff, body_last)) begin
            st_ff <= CBFC_CSUM;
            cnt_ff <= 6'h00;
          end
        end
        CBFC_CSUM: begin
          shift_ff <= nxt_shift;
          cnt_ff <= cnt_ff + 6'h01;
          if (csum_bad) begin
            st_ff <= CBFC_ERR;
          end else if (csum_last) begin
            if (ftype_ff == CBFC_F_ID) begin
              id_seen_ff <= 1'b1;
            end
            st_ff <= CBFC_GAP;
            ones_ff <= 4'h0;
          end
        end
        CBFC_POST: begin
          // checksum byte of ones counts among the closing ones
          cnt_ff <= cnt_ff + 6'h01;
          if (align_bad) begin
            st_ff <= CBFC_ERR;
          end else if (cnt_ff == post_last) begin
            st_ff <= CBFC_DONE;
          end
        end
        // RULE_17 idle until reset or program
        default: begin
          st_ff <= st_ff;
        end
      endcase
    end
  end

  function automatic logic pos_pos_last(input logic [8:0] p, input logic [8:0] last);
    pos_pos_last = (p == last);
  endfunction

  // ----------------------------------------------------------------
  // error record
  // ----------------------------------------------------------------
  logic err_id_ff;
  logic err_align_ff;
  logic err_csum_ff;

  // RULE_18 kind of error kept for the processor port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_id_ff <= 1'b0;
      err_align_ff <= 1'b0;
      err_csum_ff <= 1'b0;
    end else if (restart) begin
      err_id_ff <= 1'b0;
      err_align_ff <= 1'b0;
      err_csum_ff <= 1'b0;
    end else if (st_ff != CBFC_ERR) begin
      err_id_ff <= err_id_ff | id_bad;
      err_align_ff <= err_align_ff | align_bad;
      err_csum_ff <= err_csum_ff | csum_bad;
    end
  end

  // RULE_17 error pin low while halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_n_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      init_n_ff <= (st_ff != CBFC_ERR);
      done_ff <= (st_ff == CBFC_DONE);
    end
  end

  // ----------------------------------------------------------------
  // payload stream and frame store
  // ----------------------------------------------------------------
  logic pay_take;
  logic store_go;
  logic [13:0] auto_addr_ff;
  logic [13:0] frames_ff;

  assign pay_take = in_frame && (ftype_ff == CBFC_F_DATA) &&
                    (pos_ff >= `POS_HDR2) && (pos_ff <= PAY_LAST);
  // RULE_12 explicit frames land on every following address frame
  // RULE_20 stepping stops at the last frame of the array
  assign store_go = frame_ok && !restart &&
                    (((ftype_ff == CBFC_F_DATA) && !explicit_ff &&
                      (auto_addr_ff < FRAME_CNT)) ||
                     ((ftype_ff == CBFC_F_ADDR) && explicit_ff));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      payload_bit_ff <= 1'b0;
      payload_vld_ff <= 1'b0;
    end else begin
      payload_bit_ff <= bit_in;
      payload_vld_ff <= pay_take && !restart;
    end
  end

  // RULE_20 next address from zero in stepping mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_ff <= 1'b0;
      store_addr_ff <= 14'h0000;
      auto_addr_ff <= 14'h0000;
      frames_ff <= 14'h0000;
    end else if (restart) begin
      store_ff <= 1'b0;
      auto_addr_ff <= 14'h0000;
      frames_ff <= 14'h0000;
    end else begin
      store_ff <= store_go;
      if (store_go) begin
        store_addr_ff <= explicit_ff ? field_ff[13:0] : auto_addr_ff;
        frames_ff <= frames_ff + 14'h0001;
        if (!explicit_ff) begin
          auto_addr_ff <= auto_addr_ff + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `REG_CTRL) begin
        reg_rdata_ff <= {30'h0, mpi_mode_ff, 1'b0};
      end else if (reg_addr == `REG_STATUS) begin
        reg_rdata_ff <= {23'h0, st_ff, explicit_ff, done_ff,
                         err_csum_ff, err_align_ff, err_id_ff};
      end else if (reg_addr == `REG_LEN) begin
        reg_rdata_ff <= {8'h00, len_ff};
      end else if (reg_addr == `REG_FRAMES) begin
        reg_rdata_ff <= {2'h0, auto_addr_ff, 2'h0, frames_ff};
      end else begin
        reg_rdata_ff <= 32'h00000000;
      end
    end else begin
      reg_rdata_ff <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_err_pin;
    @(posedge clk) disable iff (!rst_n)
    (st_ff == CBFC_ERR) |=> !init_n_ff;
  endproperty
  a_err_pin: assert property (p_err_pin) else $error("error pin not low in idle"); // RULE_17

  property p_err_hold;
    @(posedge clk) disable iff (!rst_n)
    (st_ff == CBFC_ERR) && !restart |=> (st_ff == CBFC_ERR);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("left idle without restart"); // RULE_17

  property p_align;
    @(posedge clk) disable iff (!rst_n)
    bit_ev && !restart && (st_ff == CBFC_GAP) && !bit_in && (ones_ff < `STOP_BITS)
      |=> (st_ff == CBFC_ERR) && err_align_ff ##1 !init_n_ff;
  endproperty
  a_align: assert property (p_align) else $error("short stop run not flagged"); // RULE_14

  property p_csum;
    @(posedge clk) disable iff (!rst_n)
    csum_last && !restart && (nxt_shift != csum_ff) |=> err_csum_ff && (st_ff == CBFC_ERR);
  endproperty
  a_csum: assert property (p_csum) else $error("bad checksum not flagged"); // RULE_16

  property p_id;
    @(posedge clk) disable iff (!rst_n)
    in_id && !restart && (pos_ff == `ID_LAST) && (nxt_field[19:0] != PART_CODE)
      |=> err_id_ff;
  endproperty
  a_id: assert property (p_id) else $error("part code mismatch not flagged"); // RULE_05

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
    prog_wr |=> (st_ff == CBFC_HUNT) && !err_id_ff && !err_align_ff && !err_csum_ff
      ##1 init_n_ff;
  endproperty
  a_restart: assert property (p_restart) else $error("program bit did not restart"); // RULE_19

  property p_step;
    @(posedge clk) disable iff (!rst_n)
    store_ff && !explicit_ff && !$past(restart) |-> (auto_addr_ff == store_addr_ff + 14'h0001);
  endproperty
  a_step: assert property (p_step) else $error("stepping address not advanced"); // RULE_20

  property p_len;
    @(posedge clk) disable iff (!rst_n)
    bit_ev && !restart && (st_ff == CBFC_LEN) && (cnt_ff == `LEN_LAST)
      |=> (st_ff == CBFC_GAP) && (len_ff == $past(nxt_field));
  endproperty
  a_len: assert property (p_len) else $error("length count not captured"); // RULE_02

  property p_post;
    @(posedge clk) disable iff (!rst_n)
    post_hit && !restart |=> (st_ff == CBFC_POST) && (cnt_ff == 6'h00);
  endproperty
  a_post: assert property (p_post) else $error("postamble not recognised"); // RULE_11
endmodule

// file: dv/cbfc_source.sv
// serial bit stream source standing in for the prom or host processor
`timescale 1ns/1ns
module cbfc_source (
  input wire logic clk,
  output logic cfg_clk_pin,
  output logic cfg_data_pin
);
  // --------------------------------------------
  // bit and frame senders
  // --------------------------------------------
  // clock rests high between bits; data flips once its hold has run out
  initial begin
    cfg_clk_pin = 1'b1;
    cfg_data_pin = 1'b0;
  end
  // six cycles per level so the three-stage pin synchroniser always settles
  task automatic send_bit(input logic b);
    cfg_clk_pin <= 1'b0;
    cfg_data_pin <= b;
    repeat (6) @(posedge clk);
    cfg_clk_pin <= 1'b1;
    repeat (6) @(posedge clk);
    cfg_data_pin <= ~b;
    @(posedge clk);
  endtask
  task automatic send_bits(input logic [63:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) send_bit(w[i]);
  endtask
  task automatic send_stops(input int n);
    repeat (n) send_bit(1'b1);
  endtask
  task automatic send_header(input logic [23:0] len);
    send_bits({16'h0, 16'hFFF2, len, 8'hFF}, 48);
  endtask
  // bytewise xor; flip corrupts on purpose
  task automatic send_frame(input logic q[$], input logic [7:0] flip);
    logic [7:0] b;
    logic [7:0] c;
    b = 8'h00;
    c = 8'h00;
    foreach (q[i]) begin
      b = {b[6:0], q[i]};
      if (i % 8 == 7) c = c ^ b;
      send_bit(q[i]);
    end
    send_bits({56'h0, c ^ flip}, 8);
  endtask
  task automatic send_post(input int n);
    send_bits(64'h3FFF, 16);
    send_stops(n);
  endtask
endmodule

// file: dv/test_cbfc_checker.sv
// self-checking bench for the configuration bit stream frame checker
`timescale 1ns/1ns
module test_cbfc_checker;
  // --------------------------------------------
  // signals and instances
  // --------------------------------------------
  localparam int DB = 20;
  localparam logic [19:0] PC = 20'h5A3C1; // value arbitrary
  logic clk, rst_n, prog_n, wr, rd, cclk, cdat, init_n, done, store, pbit, pvld;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [13:0] saddr;
  logic [23:0] exp_len;
  logic q[$];
  logic exp_bits[$];
  logic [13:0] exp_addr[$];
  int bad_count, n_checks, seed;

  // small payload keeps a pad of two bits, so alignment padding is exercised
  cbfc_checker #(.DATA_BITS(DB), .FRAMES(4), .PART_CODE(PC)) dut (
    .clk(clk), .rst_n(rst_n), .cfg_clk_pin(cclk), .cfg_data_pin(cdat),
    .program_request_pin_n(prog_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdata), .init_n_ff(init_n),
    .done_ff(done), .store_ff(store), .store_addr_ff(saddr),
    .payload_bit_ff(pbit), .payload_vld_ff(pvld));
  cbfc_source src (.clk(clk), .cfg_clk_pin(cclk), .cfg_data_pin(cdat));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------------------------------
  // tasks
  // --------------------------------------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic reg_w(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic put(input logic [63:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) q.push_back(w[i]);
  endtask
  task automatic hdr;
    exp_len = 24'($random(seed));
    src.send_header(exp_len);
  endtask
  task automatic idf(input logic [1:0] m, input logic [19:0] code, input logic rsv);
    q = {};
    put(64'h5FFF, 16);
    put(64'(m), 2);
    put(64'(rsv), 42);
    put(64'(code), 20);
    src.send_frame(q, 8'h00);
    src.send_stops(8);
  endtask
  task automatic dataf(input logic [7:0] flip, input int stops);
    logic b;
    q = {};
    put(64'h1, 2);
    for (int i = 0; i < DB; i++) begin
      b = 1'($random(seed));
      q.push_back(b);
      exp_bits.push_back(b);
    end
    put(64'h0, (8 - (2 + DB) % 8) % 8);
    src.send_frame(q, flip);
    src.send_stops(stops);
  endtask
  task automatic addrf(input logic [13:0] a);
    q = {};
    put(64'(a), 16);
    src.send_frame(q, 8'h00);
    src.send_stops(8);
  endtask
  task automatic load(input logic [1:0] m, input logic processor_config_port);
    logic [13:0] a;
    reg_w(4'h0, {30'h0, processor_config_port, 1'b1});
    hdr;
    idf(m, PC, 1'b0);
    for (int f = 0; f < 2; f++) begin
      if (m == 2'b00) exp_addr.push_back(14'(f));
      dataf(8'h00, 8);
      for (int r = 0; r < 2 * m; r++) begin
        a = 14'($random(seed)) & 14'h1FFF;
        exp_addr.push_back(a);
        addrf(a);
      end
    end
    src.send_post(16);
    check("done_early", {31'h0, ~processor_config_port}, 32'(done));
    if (processor_config_port) src.send_stops(16);
    check("done", 32'h1, 32'(done));
    check("init_n", 32'h1, 32'(init_n));
    reg_r(4'h1);
    check("status", {24'h0, 8'hC8 | {3'h0, m[0], 4'h0}}, d);
    reg_r(4'h2);
    check("length", {8'h0, exp_len}, d);
    reg_r(4'h3);
    check("stores", 32'h2 * (1 + m), d & 32'h3FFF);
    reg_r(4'hF);
    check("unmapped", 32'h0, d);
    reg_r(4'h0);
    check("ctrl", {30'h0, processor_config_port, 1'b0}, d);
  endtask

  // payload and store pulses stand one cycle, so they are sampled at every edge
  always @(posedge clk) begin
    if (pvld === 1'b1) check("payload", 32'(exp_bits.size() ? exp_bits.pop_front() : 1'bx),
      32'(pbit));
    if (store === 1'b1) check("store_addr", 32'(exp_addr.size() ? exp_addr.pop_front() :
      14'hx), 32'(saddr));
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict;
  end

  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    rst_n = 1'b0;
    prog_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    seed = 32'hcdd5;
    bad_count = 0;
    n_checks = 0;
    do_reset;
    load(2'b00, 1'b1);
    load(2'b01, 1'b0);
    // each error kind, cleared in turn by reset, program pin and program bit, the three paths repeating
    for (int k = 0; k < 5; k++) begin
      reg_w(4'h0, 32'h1);
      hdr;
      idf(k == 1 ? 2'b10 : 2'b00, k == 0 ? PC ^ 20'h1 : PC, k == 2);
      if (k == 4) exp_addr.push_back(14'h0);
      if (k > 2) dataf(k == 3 ? 8'h10 : 8'h00, k == 3 ? 8 : 0);
      if (k == 4) src.send_bits(64'h3F9, 10);
      check("init_n_err", 32'h0, 32'(init_n));
      reg_r(4'h1);
      check("err_status", k < 3 ? 32'hE1 : k == 3 ? 32'hE4 : 32'hE2, d);
      if (k % 3 == 0) do_reset;
      else if (k % 3 == 1) begin
        prog_n <= 1'b0;
        repeat (6) @(posedge clk);
        prog_n <= 1'b1;
        repeat (6) @(posedge clk);
      end else reg_w(4'h0, 32'h1);
      reg_r(4'h1);
      check("restart", 32'h0, d & 32'hEF);
      check("init_n_clr", 32'h1, 32'(init_n));
    end
    check("left", 32'h0, 32'(exp_bits.size() + exp_addr.size()));
    print_verdict;
  end
endmodule
